// *** logic/cfab_consts.svh ***
`ifndef CFAB_CONSTS_SVH
`define CFAB_CONSTS_SVH

`define CFAB_ADDR_W     24
`define CFAB_DATA_W     32
`define CFAB_STRB_W     4
`define CFAB_PROT_W     3
`define CFAB_PORTS      3
`define CFAB_PORT_LOG   2'h0
`define CFAB_PORT_BUF   2'h1
`define CFAB_PORT_PHY   2'h2
`define CFAB_LOG_LAST   24'h00_00fc
`define CFAB_PHY_LAST   24'h00_fffc
`define CFAB_RESP_OKAY  2'h0
`define CFAB_RESP_ERR   2'h2
`define CFAB_PROT_ZERO  3'h0
`define CFAB_MEM_WORDS  16
`define CFAB_MEM_IDX_LO 2
`define CFAB_MEM_IDX_HI 5

`endif

// *** logic/cfab_pkg.sv ***
package cfab_pkg;
   typedef logic [1:0] cfab_port_t;
   typedef logic [1:0] cfab_resp_t;

   typedef enum logic [2:0] {
      CFAB_S_IDLE = 3'b000,
      CFAB_S_WACC = 3'b001,
      CFAB_S_WFWD = 3'b010,
      CFAB_S_WRSP = 3'b011,
      CFAB_S_WUP  = 3'b100,
      CFAB_S_RACC = 3'b101,
      CFAB_S_RFWD = 3'b110,
      CFAB_S_RUP  = 3'b111
   } cfab_state_t;

   typedef enum logic [2:0] {
      CFAB_M_IDLE = 3'b000,
      CFAB_M_WR   = 3'b001,
      CFAB_M_B    = 3'b010,
      CFAB_M_RD   = 3'b011,
      CFAB_M_R    = 3'b100
   } cfab_mstate_t;
endpackage

// *** logic/cfab_if.sv ***
`timescale 1ns/100ps
`include "cfab_consts.svh"
interface cfab_if;
   // upstream port: partner master, fabric slave
   logic                                   up_awvalid;
   logic                                   up_awready;
   logic [`CFAB_ADDR_W-1:0]                up_awaddr;
   logic [`CFAB_PROT_W-1:0]                up_awprot;
   logic                                   up_wvalid;
   logic                                   up_wready;
   logic [`CFAB_DATA_W-1:0]                up_wdata;
   logic [`CFAB_STRB_W-1:0]                up_wstrb;
   logic                                   up_bvalid;
   logic                                   up_bready;
   logic [1:0]                             up_bresp;
   logic                                   up_arvalid;
   logic                                   up_arready;
   logic [`CFAB_ADDR_W-1:0]                up_araddr;
   logic [`CFAB_PROT_W-1:0]                up_arprot;
   logic                                   up_rvalid;
   logic                                   up_rready;
   logic [1:0]                             up_rresp;
   logic [`CFAB_DATA_W-1:0]                up_rdata;
   // downstream ports, index 0 logical, 1 buffer, 2 physical
   logic [`CFAB_PORTS-1:0]                 dn_awvalid;
   logic [`CFAB_PORTS-1:0]                 dn_awready;
   logic [`CFAB_ADDR_W-1:0]                dn_awaddr;
   logic [`CFAB_PROT_W-1:0]                dn_awprot;
   logic [`CFAB_PORTS-1:0]                 dn_wvalid;
   logic [`CFAB_PORTS-1:0]                 dn_wready;
   logic [`CFAB_DATA_W-1:0]                dn_wdata;
   logic [`CFAB_STRB_W-1:0]                dn_wstrb;
   logic [`CFAB_PORTS-1:0]                 dn_bvalid;
   logic [`CFAB_PORTS-1:0]                 dn_bready;
   logic [`CFAB_PORTS-1:0]                 dn_arvalid;
   logic [`CFAB_PORTS-1:0]                 dn_arready;
   logic [`CFAB_ADDR_W-1:0]                dn_araddr;
   logic [`CFAB_PROT_W-1:0]                dn_arprot;
   logic [`CFAB_PORTS-1:0]                 dn_rvalid;
   logic [`CFAB_PORTS-1:0]                 dn_rready;
   logic [`CFAB_PORTS-1:0][`CFAB_DATA_W-1:0] dn_rdata;

   modport fabric (
      input  up_awvalid, up_awaddr, up_awprot, up_wvalid, up_wdata, up_wstrb, up_bready,
      input  up_arvalid, up_araddr, up_arprot, up_rready,
      output up_awready, up_wready, up_bvalid, up_bresp, up_arready, up_rvalid,
      output up_rresp, up_rdata,
      output dn_awvalid, dn_awaddr, dn_awprot, dn_wvalid, dn_wdata, dn_wstrb, dn_bready,
      output dn_arvalid, dn_araddr, dn_arprot, dn_rready,
      input  dn_awready, dn_wready, dn_bvalid, dn_arready, dn_rvalid, dn_rdata
   );
   modport cores (
      output up_awvalid, up_awaddr, up_awprot, up_wvalid, up_wdata, up_wstrb, up_bready,
      output up_arvalid, up_araddr, up_arprot, up_rready,
      input  up_awready, up_wready, up_bvalid, up_bresp, up_arready, up_rvalid,
      input  up_rresp, up_rdata,
      input  dn_awvalid, dn_awaddr, dn_awprot, dn_wvalid, dn_wdata, dn_wstrb, dn_bready,
      input  dn_arvalid, dn_araddr, dn_arprot, dn_rready,
      output dn_awready, dn_wready, dn_bvalid, dn_arready, dn_rvalid, dn_rdata
   );
endinterface

// *** logic/cfab_cores.sv ***
`timescale 1ns/100ps
`include "cfab_consts.svh"
module cfab_cores (
   // clock and reset
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_i,
   // user request
   input  wire logic                    req_valid_i,
   input  wire logic                    req_write_i,
   input  wire logic [`CFAB_ADDR_W-1:0] req_addr_i,
   input  wire logic [`CFAB_DATA_W-1:0] req_wdata_i,
   input  wire logic [`CFAB_STRB_W-1:0] req_wstrb_i,
   output logic                         req_ready_o,
   // user completion
   output logic                         done_o,
   output cfab_pkg::cfab_resp_t         done_resp_o,
   output logic [`CFAB_DATA_W-1:0]      done_rdata_o,
   // fabric side
   cfab_if.cores                        bus
);
   import cfab_pkg::*;

   cfab_mstate_t            mst_q;
   logic                    awvalid_q, wvalid_q, bready_q, arvalid_q, rready_q;
   logic [`CFAB_ADDR_W-1:0] addr_q;
   logic [`CFAB_DATA_W-1:0] wdata_q;
   logic [`CFAB_STRB_W-1:0] wstrb_q;

   wire req_take = req_ready_o & req_valid_i;

   assign bus.up_awvalid = awvalid_q;
   assign bus.up_wvalid  = wvalid_q;
   assign bus.up_bready  = bready_q;
   assign bus.up_arvalid = arvalid_q;
   assign bus.up_rready  = rready_q;
   assign bus.up_awaddr  = addr_q;
   assign bus.up_araddr  = addr_q;
   assign bus.up_wdata   = wdata_q;
   assign bus.up_wstrb   = wstrb_q;
   assign bus.up_awprot  = `CFAB_PROT_ZERO;
   assign bus.up_arprot  = `CFAB_PROT_ZERO;

   // logical-layer master: one maintenance access at a time
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         mst_q        <= CFAB_M_IDLE;
         req_ready_o  <= 1'b0;
         awvalid_q    <= 1'b0;
         wvalid_q     <= 1'b0;
         bready_q     <= 1'b0;
         arvalid_q    <= 1'b0;
         rready_q     <= 1'b0;
         addr_q       <= '0;
         wdata_q      <= '0;
         wstrb_q      <= '0;
         done_o       <= 1'b0;
         done_resp_o  <= `CFAB_RESP_OKAY;
         done_rdata_o <= '0;
      end else begin
         done_o <= 1'b0;
         unique case (mst_q)
            CFAB_M_IDLE: begin
               req_ready_o <= ~req_take;
               if (req_take) begin
                  addr_q    <= req_addr_i;
                  wdata_q   <= req_wdata_i;
                  wstrb_q   <= req_wstrb_i;
                  awvalid_q <= req_write_i;
                  wvalid_q  <= req_write_i;
                  arvalid_q <= ~req_write_i;
                  mst_q     <= req_write_i ? CFAB_M_WR : CFAB_M_RD;
               end
            end
            CFAB_M_WR: begin
               // valids hold until each handshake
               if (bus.up_awready) awvalid_q <= 1'b0;
               if (bus.up_wready) wvalid_q <= 1'b0;
               if ((~awvalid_q | bus.up_awready) & (~wvalid_q | bus.up_wready)) begin
                  bready_q <= 1'b1;
                  mst_q    <= CFAB_M_B;
               end
            end
            CFAB_M_B: if (bus.up_bvalid) begin
               bready_q    <= 1'b0;
               done_o      <= 1'b1;
               done_resp_o <= bus.up_bresp;
               req_ready_o <= 1'b1;
               mst_q       <= CFAB_M_IDLE;
            end
            CFAB_M_RD: if (bus.up_arready) begin
               arvalid_q <= 1'b0;
               rready_q  <= 1'b1;
               mst_q     <= CFAB_M_R;
            end
            CFAB_M_R: if (bus.up_rvalid) begin
               rready_q     <= 1'b0;
               done_o       <= 1'b1;
               done_resp_o  <= bus.up_rresp;
               done_rdata_o <= bus.up_rdata;
               req_ready_o  <= 1'b1;
               mst_q        <= CFAB_M_IDLE;
            end
            default: mst_q <= CFAB_M_IDLE;
         endcase
      end
   end

   function automatic logic [`CFAB_DATA_W-1:0] merge_lanes(
      input logic [`CFAB_DATA_W-1:0] old_w,
      input logic [`CFAB_DATA_W-1:0] new_w,
      input logic [`CFAB_STRB_W-1:0] strb
   );
      logic [`CFAB_DATA_W-1:0] res;
      res = old_w;
      for (int i = 0; i < `CFAB_STRB_W; i++) begin
         if (strb[i]) res[i*8 +: 8] = new_w[i*8 +: 8];
      end
      return res;
   endfunction

   // one small configuration slave per core; index taken from the word address
   for (genvar g = 0; g < `CFAB_PORTS; g++) begin : g_slv
      logic                    awr_q, bvalid_q, arr_q, rvalid_q;
      logic [`CFAB_DATA_W-1:0] rdata_q;
      logic [`CFAB_DATA_W-1:0] mem_q [`CFAB_MEM_WORDS];
      wire wr_both = bus.dn_awvalid[g] & bus.dn_wvalid[g];
      wire wr_hs   = awr_q & wr_both;
      wire rd_hs   = arr_q & bus.dn_arvalid[g];
      wire [3:0] widx = bus.dn_awaddr[`CFAB_MEM_IDX_HI:`CFAB_MEM_IDX_LO];
      wire [3:0] ridx = bus.dn_araddr[`CFAB_MEM_IDX_HI:`CFAB_MEM_IDX_LO];

      assign bus.dn_awready[g] = awr_q;
      assign bus.dn_wready[g]  = awr_q;
      assign bus.dn_bvalid[g]  = bvalid_q;
      assign bus.dn_arready[g] = arr_q;
      assign bus.dn_rvalid[g]  = rvalid_q;
      assign bus.dn_rdata[g]   = rdata_q;

      // answers each request from the fabric
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
         if (rst_i) begin
            awr_q    <= 1'b0;
            bvalid_q <= 1'b0;
            arr_q    <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            for (int k = 0; k < `CFAB_MEM_WORDS; k++) mem_q[k] <= '0;
         end else begin
            awr_q <= wr_both & ~awr_q & ~bvalid_q;
            arr_q <= bus.dn_arvalid[g] & ~arr_q & ~rvalid_q;
            if (wr_hs) begin
               mem_q[widx] <= merge_lanes(mem_q[widx], bus.dn_wdata, bus.dn_wstrb);
               bvalid_q    <= 1'b1;
            end else if (bus.dn_bready[g]) begin
               bvalid_q <= 1'b0;
            end
            if (rd_hs) begin
               rdata_q  <= mem_q[ridx];
               rvalid_q <= 1'b1;
            end else if (bus.dn_rready[g]) begin
               rvalid_q <= 1'b0;
            end
         end
      end
   end
endmodule

// *** logic/cfab_fabric.sv ***
`timescale 1ns/100ps
`include "cfab_consts.svh"
// Function
// - fabric is sole master, arbitrates all accesses
// - each core configuration module is a slave
// - logical core feeds requests through master port
// - configuration clock equals logical-layer clock
// - reset releases synchronously, asserts any time
// - response codes: 00 ok, 10 error
// - write address 24 bits, valid-ready handshake
// - write data 32 bits, valid-ready handshake
// - four byte strobes passed on unchanged
// - write response completes on valid and ready
// - read address 24 bits, valid-ready handshake
// - read data 32 bits with handshaked response
// - separate full ports for logical and buffer; here all three ports share address and write data, valids per port
// - route offsets to logical, physical, buffer
module cfab_fabric (
   // clock and reset, same clock as the logical layer
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   // upstream port and all three downstream ports
   cfab_if.fabric    bus
);
   import cfab_pkg::*;

   function automatic cfab_port_t route(input logic [`CFAB_ADDR_W-1:0] addr);
      if (addr <= `CFAB_LOG_LAST) return `CFAB_PORT_LOG;
      else if (addr <= `CFAB_PHY_LAST) return `CFAB_PORT_PHY;
      else return `CFAB_PORT_BUF;
   endfunction

   function automatic logic [`CFAB_PORTS-1:0] onehot(input cfab_port_t idx);
      return `CFAB_PORTS'(3'b001 << idx);
   endfunction

   cfab_state_t               state_q,      state_d;
   cfab_port_t                sel_q,        sel_d;
   logic [`CFAB_ADDR_W-1:0]   addr_q,       addr_d;
   logic [`CFAB_DATA_W-1:0]   wdata_q,      wdata_d;
   logic [`CFAB_STRB_W-1:0]   wstrb_q,      wstrb_d;
   logic [`CFAB_DATA_W-1:0]   rdata_q,      rdata_d;
   logic                      up_awr_q,     up_awr_d;
   logic                      up_arr_q,     up_arr_d;
   logic                      up_bvalid_q,  up_bvalid_d;
   logic                      up_rvalid_q,  up_rvalid_d;
   logic                      last_wr_q,    last_wr_d;
   logic [`CFAB_PORTS-1:0]    dn_awv_q,     dn_awv_d;
   logic [`CFAB_PORTS-1:0]    dn_wv_q,      dn_wv_d;
   logic [`CFAB_PORTS-1:0]    dn_bready_q,  dn_bready_d;
   logic [`CFAB_PORTS-1:0]    dn_arv_q,     dn_arv_d;
   logic [`CFAB_PORTS-1:0]    dn_rready_q,  dn_rready_d;

   // decode and handshake terms
   wire cfab_port_t             aw_port  = route(bus.up_awaddr);
   wire cfab_port_t             ar_port  = route(bus.up_araddr);
   wire [`CFAB_PORTS-1:0]       sel_oh   = onehot(sel_q);
   wire                         wr_req   = bus.up_awvalid & bus.up_wvalid;
   wire                         rd_req   = bus.up_arvalid;
   // alternate when both kinds wait so neither starves
   wire                         take_wr  = wr_req & (~rd_req | ~last_wr_q);
   wire                         aw_hs    = |(dn_awv_q & bus.dn_awready);
   wire                         w_hs     = |(dn_wv_q & bus.dn_wready);
   wire                         aw_done  = ~(|dn_awv_q) | aw_hs;
   wire                         w_done   = ~(|dn_wv_q) | w_hs;
   wire                         b_hs     = |(dn_bready_q & bus.dn_bvalid);
   wire                         ar_hs    = |(dn_arv_q & bus.dn_arready);
   wire                         r_hs     = |(dn_rready_q & bus.dn_rvalid);
   wire [`CFAB_DATA_W-1:0]      sel_rdat = bus.dn_rdata[sel_q];

   // upstream slave port
   assign bus.up_awready = up_awr_q;
   assign bus.up_wready  = up_awr_q;
   assign bus.up_arready = up_arr_q;
   assign bus.up_bvalid  = up_bvalid_q;
   assign bus.up_rvalid  = up_rvalid_q;
   assign bus.up_rdata   = rdata_q;
   // downstream ports carry no response code, so completion means success
   assign bus.up_bresp   = `CFAB_RESP_OKAY;
   assign bus.up_rresp   = `CFAB_RESP_OKAY;

   // downstream master ports, address and data shared, valids per port
   assign bus.dn_awvalid = dn_awv_q;
   assign bus.dn_wvalid  = dn_wv_q;
   assign bus.dn_bready  = dn_bready_q;
   assign bus.dn_arvalid = dn_arv_q;
   assign bus.dn_rready  = dn_rready_q;
   assign bus.dn_awaddr  = addr_q;
   assign bus.dn_araddr  = addr_q;
   assign bus.dn_wdata   = wdata_q;
   assign bus.dn_wstrb   = wstrb_q;
   assign bus.dn_awprot  = `CFAB_PROT_ZERO;
   assign bus.dn_arprot  = `CFAB_PROT_ZERO;

   always_comb begin
      state_d     = state_q;
      sel_d       = sel_q;
      addr_d      = addr_q;
      wdata_d     = wdata_q;
      wstrb_d     = wstrb_q;
      rdata_d     = rdata_q;
      up_awr_d    = up_awr_q;
      up_arr_d    = up_arr_q;
      up_bvalid_d = up_bvalid_q;
      up_rvalid_d = up_rvalid_q;
      last_wr_d   = last_wr_q;
      dn_awv_d    = dn_awv_q;
      dn_wv_d     = dn_wv_q;
      dn_bready_d = dn_bready_q;
      dn_arv_d    = dn_arv_q;
      dn_rready_d = dn_rready_q;
      unique case (state_q)
         // only here is a new access taken, so one is in flight at a time
         CFAB_S_IDLE: begin
            if (take_wr) begin
               up_awr_d = 1'b1;
               state_d  = CFAB_S_WACC;
            end else if (rd_req) begin
               up_arr_d = 1'b1;
               state_d  = CFAB_S_RACC;
            end
         end
         // valids still high, so address and data transfer in this cycle
         CFAB_S_WACC: begin
            up_awr_d  = 1'b0;
            addr_d    = bus.up_awaddr;
            wdata_d   = bus.up_wdata;
            wstrb_d   = bus.up_wstrb;
            sel_d     = aw_port;
            dn_awv_d  = onehot(aw_port);
            dn_wv_d   = onehot(aw_port);
            last_wr_d = 1'b1;
            state_d   = CFAB_S_WFWD;
         end
         CFAB_S_WFWD: begin
            if (aw_hs) dn_awv_d = '0;
            if (w_hs) dn_wv_d = '0;
            if (aw_done & w_done) begin
               dn_bready_d = sel_oh;
               state_d     = CFAB_S_WRSP;
            end
         end
         CFAB_S_WRSP: begin
            if (b_hs) begin
               dn_bready_d = '0;
               up_bvalid_d = 1'b1;
               state_d     = CFAB_S_WUP;
            end
         end
         CFAB_S_WUP: begin
            if (bus.up_bready) begin
               up_bvalid_d = 1'b0;
               state_d     = CFAB_S_IDLE;
            end
         end
         CFAB_S_RACC: begin
            up_arr_d  = 1'b0;
            addr_d    = bus.up_araddr;
            sel_d     = ar_port;
            dn_arv_d  = onehot(ar_port);
            last_wr_d = 1'b0;
            state_d   = CFAB_S_RFWD;
         end
         CFAB_S_RFWD: begin
            if (ar_hs) begin
               dn_arv_d    = '0;
               dn_rready_d = sel_oh;
            end
            if (r_hs) begin
               dn_rready_d = '0;
               rdata_d     = sel_rdat;
               up_rvalid_d = 1'b1;
               state_d     = CFAB_S_RUP;
            end
         end
         CFAB_S_RUP: begin
            if (bus.up_rready) begin
               up_rvalid_d = 1'b0;
               state_d     = CFAB_S_IDLE;
            end
         end
      endcase
   end

   // reset may arrive at any time; release is assumed synchronous
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_q     <= CFAB_S_IDLE;
         sel_q       <= `CFAB_PORT_LOG;
         addr_q      <= '0;
         wdata_q     <= '0;
         wstrb_q     <= '0;
         rdata_q     <= '0;
         up_awr_q    <= 1'b0;
         up_arr_q    <= 1'b0;
         up_bvalid_q <= 1'b0;
         up_rvalid_q <= 1'b0;
         last_wr_q   <= 1'b0;
         dn_awv_q    <= '0;
         dn_wv_q     <= '0;
         dn_bready_q <= '0;
         dn_arv_q    <= '0;
         dn_rready_q <= '0;
      end else begin
         state_q     <= state_d;
         sel_q       <= sel_d;
         addr_q      <= addr_d;
         wdata_q     <= wdata_d;
         wstrb_q     <= wstrb_d;
         rdata_q     <= rdata_d;
         up_awr_q    <= up_awr_d;
         up_arr_q    <= up_arr_d;
         up_bvalid_q <= up_bvalid_d;
         up_rvalid_q <= up_rvalid_d;
         last_wr_q   <= last_wr_d;
         dn_awv_q    <= dn_awv_d;
         dn_wv_q     <= dn_wv_d;
         dn_bready_q <= dn_bready_d;
         dn_arv_q    <= dn_arv_d;
         dn_rready_q <= dn_rready_d;
      end
   end
endmodule

// *** verif/cfab_props.sv ***
`timescale 1ns/100ps
`include "cfab_consts.svh"
module cfab_props (
   // clock and reset
   input wire logic                    clk_sys_i,
   input wire logic                    rst_i,
   // upstream port
   input wire logic                    up_awvalid,
   input wire logic                    up_awready,
   input wire logic                    up_wvalid,
   input wire logic                    up_wready,
   input wire logic [`CFAB_STRB_W-1:0] up_wstrb,
   input wire logic                    up_bvalid,
   input wire logic                    up_bready,
   input wire logic [1:0]              up_bresp,
   input wire logic                    up_arvalid,
   input wire logic                    up_arready,
   input wire logic                    up_rvalid,
   input wire logic [1:0]              up_rresp,
   // downstream ports
   input wire logic [`CFAB_PORTS-1:0]  dn_awvalid,
   input wire logic [`CFAB_PORTS-1:0]  dn_awready,
   input wire logic [`CFAB_ADDR_W-1:0] dn_awaddr,
   input wire logic [`CFAB_PROT_W-1:0] dn_awprot,
   input wire logic [`CFAB_PORTS-1:0]  dn_wvalid,
   input wire logic [`CFAB_STRB_W-1:0] dn_wstrb,
   input wire logic [`CFAB_PORTS-1:0]  dn_arvalid,
   input wire logic [`CFAB_ADDR_W-1:0] dn_araddr,
   input wire logic [`CFAB_PROT_W-1:0] dn_arprot
);
   logic [`CFAB_STRB_W-1:0] strb_q;
   // one-hot port expected from the address, index 0 logical, 1 buffer, 2 physical
   wire [2:0] aw_port_w = (dn_awaddr <= `CFAB_LOG_LAST) ? 3'h1 :
                          (dn_awaddr <= `CFAB_PHY_LAST) ? 3'h4 : 3'h2;
   wire [2:0] ar_port_w = (dn_araddr <= `CFAB_LOG_LAST) ? 3'h1 :
                          (dn_araddr <= `CFAB_PHY_LAST) ? 3'h4 : 3'h2;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) strb_q <= '0;
      else if (up_wvalid && up_wready) strb_q <= up_wstrb;
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_wtake; up_awvalid && up_awready; endsequence
   sequence s_rtake; up_arvalid && up_arready; endsequence
   property p_aw_with_w; up_awready |-> up_wready && up_awvalid && up_wvalid; endproperty
   a_aw_with_w: assert property (p_aw_with_w) else $error("aw accepted apart from w");
   property p_ready_pulse; up_awready || up_arready |=> !up_awready && !up_arready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
   property p_one_port; $onehot0({dn_awvalid, dn_arvalid}); endproperty
   a_one_port: assert property (p_one_port) else $error("two slave ports busy");
   property p_route_wr; |dn_awvalid |-> dn_awvalid == aw_port_w && dn_wvalid == aw_port_w;
   endproperty
   a_route_wr: assert property (p_route_wr) else $error("write misrouted");
   property p_route_rd; |dn_arvalid |-> dn_arvalid == ar_port_w; endproperty
   a_route_rd: assert property (p_route_rd) else $error("read misrouted");
   property p_strb; |dn_wvalid |-> dn_wstrb == strb_q; endproperty
   a_strb: assert property (p_strb) else $error("strobes altered");
   property p_prot; |{dn_awvalid, dn_arvalid} |-> dn_awprot == 3'h0 && dn_arprot == 3'h0;
   endproperty
   a_prot: assert property (p_prot) else $error("protection not zero");
   property p_resp;
      (up_bvalid |-> up_bresp == 2'h0) and (up_rvalid |-> up_rresp == 2'h0);
   endproperty
   a_resp: assert property (p_resp) else $error("response not success");
   property p_b_hold; up_bvalid && !up_bready |=> up_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_dn_hold; |(dn_awvalid & ~dn_awready) |=> $stable(dn_awvalid) && $stable(dn_awaddr);
   endproperty
   a_dn_hold: assert property (p_dn_hold) else $error("slave address dropped");
   property p_wr_answer; s_wtake |=> !up_bvalid [*3] ##[1:20] up_bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer timing");
   property p_rd_answer; s_rtake |=> !up_rvalid [*2] ##[1:20] up_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer timing");
endmodule

// *** verif/config_fabric_axil_router_bench.sv ***
`timescale 1ns/100ps
`include "cfab_consts.svh"
module config_fabric_axil_router_bench;
   import cfab_pkg::*;
   logic                    clk_sys_i, rst_i, req_valid_i, req_write_i, req_ready_o, done_o;
   logic [`CFAB_ADDR_W-1:0] req_addr_i;
   logic [`CFAB_DATA_W-1:0] req_wdata_i, done_rdata_o, rd_v, exp_v;
   logic [`CFAB_STRB_W-1:0] req_wstrb_i;
   cfab_resp_t              done_resp_o;
   int                      bad_count, checks;
   logic [23:0]             adr_tab [6] = '{24'h00_0000, 24'h00_00fc, 24'h00_0100,
                                            24'h00_fffc, 24'h01_0000, 24'hff_fffc};
   cfab_if bus_if ();
   // one clock feeds the fabric and the logical-layer end alike
   cfab_fabric cfab_fabric_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(bus_if));
   cfab_cores cfab_cores_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
      .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_wstrb_i(req_wstrb_i), .req_ready_o(req_ready_o), .done_o(done_o),
      .done_resp_o(done_resp_o), .done_rdata_o(done_rdata_o), .bus(bus_if));
   cfab_props cfab_props_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .up_awvalid(bus_if.up_awvalid), .up_awready(bus_if.up_awready),
      .up_wvalid(bus_if.up_wvalid), .up_wready(bus_if.up_wready), .up_wstrb(bus_if.up_wstrb),
      .up_bvalid(bus_if.up_bvalid), .up_bready(bus_if.up_bready), .up_bresp(bus_if.up_bresp),
      .up_arvalid(bus_if.up_arvalid), .up_arready(bus_if.up_arready),
      .up_rvalid(bus_if.up_rvalid), .up_rresp(bus_if.up_rresp),
      .dn_awvalid(bus_if.dn_awvalid), .dn_awready(bus_if.dn_awready),
      .dn_awaddr(bus_if.dn_awaddr), .dn_awprot(bus_if.dn_awprot),
      .dn_wvalid(bus_if.dn_wvalid), .dn_wstrb(bus_if.dn_wstrb),
      .dn_arvalid(bus_if.dn_arvalid), .dn_araddr(bus_if.dn_araddr),
      .dn_arprot(bus_if.dn_arprot));

   always #5 clk_sys_i = ~clk_sys_i;

   task automatic tally_and_finish();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic cmp_data(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_resp(input string nm, input cfab_resp_t e, input cfab_resp_t g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // request held until taken, then completion pulse sampled mid-cycle
   task automatic access(input logic wr, input logic [23:0] a, input logic [31:0] d,
                         input logic [3:0] s);
      int n;
      @(posedge clk_sys_i);
      #1;
      req_valid_i = 1'b1;
      req_write_i = wr;
      req_addr_i = a;
      req_wdata_i = d;
      req_wstrb_i = s;
      n = 0;
      do begin @(negedge clk_sys_i); n++; end while (req_ready_o !== 1'b1 && n < 50);
      if (req_ready_o !== 1'b1) begin
         bad_count++;
         $display("unexpected req_ready_o expected 1 seen timeout");
         tally_and_finish();
      end else begin
         @(posedge clk_sys_i);
         #1;
         req_valid_i = 1'b0;
         n = 0;
         do begin @(negedge clk_sys_i); n++; end while (done_o !== 1'b1 && n < 50);
         if (done_o !== 1'b1) begin
            bad_count++;
            $display("unexpected done_o expected 1 seen timeout");
            tally_and_finish();
         end else begin
            rd_v = done_rdata_o;
            cmp_resp("done_resp_o", `CFAB_RESP_OKAY, done_resp_o);
         end
      end
   endtask

   initial begin
      clk_sys_i = 1'b0;
      rst_i = 1'b1;
      req_valid_i = 1'b0;
      req_write_i = 1'b0;
      req_addr_i = '0;
      req_wdata_i = '0;
      req_wstrb_i = '0;
      repeat (8) @(posedge clk_sys_i);
      #1 rst_i = 1'b0;
      // same word indices, 0 and 15, on every port, so a misroute overwrites a neighbour
      for (int i = 0; i < 6; i++) access(1'b1, adr_tab[i], 32'hc0de_0000 + 32'(i), 4'hf);
      for (int i = 0; i < 6; i++) begin
         access(1'b0, adr_tab[i], 32'h0000_0000, 4'h0);
         cmp_data("routed read", 32'hc0de_0000 + 32'(i), rd_v);
      end
      exp_v = 32'hffff_ffff;
      access(1'b1, 24'h00_0008, exp_v, 4'hf);
      for (int j = 0; j < 5; j++) begin
         access(1'b1, 24'h00_0008, 32'h0000_0000, (j == 0) ? 4'h0 : 4'(1 << (j - 1)));
         if (j > 0) exp_v[8*(j-1) +: 8] = 8'h00;
         access(1'b0, 24'h00_0008, 32'h0000_0000, 4'h0);
         cmp_data("strobed word", exp_v, rd_v);
      end
      // reset in mid-run, then the fabric must serve traffic again
      @(posedge clk_sys_i);
      #1 rst_i = 1'b1;
      repeat (2) @(posedge clk_sys_i);
      #1 cmp_data("req_ready_o in reset", 32'h0000_0000, {31'h0, req_ready_o});
      rst_i = 1'b0;
      access(1'b1, 24'h01_0004, 32'h1234_5678, 4'hf);
      access(1'b0, 24'h01_0004, 32'h0000_0000, 4'h0);
      cmp_data("read after reset", 32'h1234_5678, rd_v);
      tally_and_finish();
   end
endmodule
